//--- src/pm_regs_defines.vh
// Offsets, field layouts and fixed values of the power-management registers
`ifndef PM_REGS_DEFINES_VH
`define PM_REGS_DEFINES_VH

// Register indices; each byte address is four times its index
`define PM_CAP_IDX 10'h0A2
`define PM_CSR_IDX 10'h0A4
`define PM_IRQ_STAT_IDX 10'h0C0
`define PM_IRQ_MASK_IDX 10'h0C1
`define PM_ADDR_W 12

// Capability register fields
`define CAP_WAKE_SUP_HI 15
`define CAP_WAKE_SUP_LO 11
`define CAP_WAKE_SUP_VAL 5'h0F
`define CAP_D2_BIT 10
`define CAP_D2_VAL 1'b1
`define CAP_D1_BIT 9
`define CAP_D1_VAL 1'b1
`define CAP_RSVD_HI 8
`define CAP_RSVD_LO 6
`define CAP_RSVD_VAL 3'h0
`define CAP_DSI_BIT 5
`define CAP_DSI_VAL 1'b1
`define CAP_AUX_BIT 4
`define CAP_AUX_VAL 1'b0
`define CAP_CLK_BIT 3
`define CAP_CLK_VAL 1'b0
`define CAP_VER_HI 2
`define CAP_VER_LO 0
`define CAP_VER_VAL 3'h1

// Control/status register fields
`define CSR_WAKE_FLAG_BIT 15
`define CSR_WAKE_EN_BIT 8
`define CSR_PSTATE_HI 1
`define CSR_PSTATE_LO 0
`define CSR_RESET 16'h0000
`define PSTATE_D0 2'h0
`define PSTATE_D1 2'h1
`define PSTATE_D2 2'h2
`define PSTATE_D3HOT 2'h3

// Interrupt status and mask layout
`define IRQ_WAKE_BIT 0
`define IRQ_PSTATE_BIT 1
`define IRQ_W 2
`define IRQ_STAT_RESET 2'h0
`define IRQ_MASK_RESET 2'h0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- src/sync2.v
// Two-flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
   input wire mclk,
   input wire rstn,
   input wire asyncIn,
   output wire syncOut
);
   reg meta_q;
   reg stable_q;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         stable_q <= 1'b0;
      end else begin
         meta_q <= asyncIn;
         stable_q <= meta_q;
      end
   end

   assign syncOut = stable_q;
endmodule

//--- src/wake_event_ctrl.v
// Sticky wake event flag and the gated wake output it drives
`timescale 1ns/1ps
module wake_event_ctrl (
   input wire mclk,
   input wire rstn,
   input wire eventPulse,
   input wire clearReq,
   input wire wakeEnable,
   output reg wakeFlag,
   output reg wakeOut
);
   reg flag_d;

   always @* begin
      flag_d = wakeFlag;
      if (clearReq) begin
         flag_d = 1'b0;
      end
      // Set is independent of the enable and beats a same-cycle clear
      if (eventPulse) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wakeFlag <= 1'b0;
         wakeOut <= 1'b0;
      end else begin
         wakeFlag <= flag_d;
         // Output follows the flag only while enabled; clearing drops it
         wakeOut <= flag_d & wakeEnable;
      end
   end
endmodule

//--- src/pm_regs_top.v
// Power-management capability and control/status registers on AXI4-Lite
//
// How it works
// RULE_01: Capability bits 15..11 always read 01111b; writes leave them alone.
// RULE_02: Capability bit 15 reads zero: no wake from cold D3.
// RULE_03: Capability bit 14 reads one: wake possible from D3hot.
// RULE_04: Capability bit 13 reads one: wake possible from D2.
// RULE_05: Capability bit 12 reads one: wake possible from D1.
// RULE_06: Capability bit 11 reads one, completing the wake support pattern.
// RULE_07: Bit 11 means wake possible from D0, so events count in D0.
// RULE_08: Capability bit 10 reads one: D2 state supported.
// RULE_09: Capability bit 9 reads one: D1 state supported.
// RULE_10: Capability bits 8..6 are reserved and read 000b.
// RULE_11: Capability bit 5 reads one: device-specific setup is needed.
// RULE_12: Capability bit 4, auxiliary power flag, reads zero.
// RULE_13: Capability bit 3 reads zero: wake needs no host bus clock.
// RULE_14: Capability bits 2..0 read 001b, the interface version.
// RULE_15: Every write to the capability register is ignored.
// RULE_16: Wake flag sets on any wake event; writing one clears flag and wake.
// RULE_17: Control bit 8 gates the wake output; cleared means never driven.
// RULE_18: Control bits 1..0 hold and report power state D0, D1, D2, D3hot.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pm_regs_defines.vh"
module pm_regs_top #(
   parameter ADDR_W = `PM_ADDR_W
) (
   input wire mclk,
   input wire rstn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire wakeEventPin,
   output wire wakeOut,
   output reg [1:0] powerStateOut,
   output reg irq
);
   localparam [2:0] SEL_NONE = 3'h0;
   localparam [2:0] SEL_CAP = 3'h1;
   localparam [2:0] SEL_CSR = 3'h2;
   localparam [2:0] SEL_STAT = 3'h3;
   localparam [2:0] SEL_MASK = 3'h4;
   localparam [15:0] CSR_INIT = `CSR_RESET;

   // Word-aligned byte address of a register index
   function [ADDR_W-1:0] byteAddr;
      input [9:0] idx;
      begin
         byteAddr = {idx, 2'b00};
      end
   endfunction

   // Register select for an address, shared by read and write paths
   function [2:0] decodeAddr;
      input [ADDR_W-1:0] addr;
      begin
         if (addr == byteAddr(`PM_CAP_IDX)) begin
            decodeAddr = SEL_CAP;
         end else if (addr == byteAddr(`PM_CSR_IDX)) begin
            decodeAddr = SEL_CSR;
         end else if (addr == byteAddr(`PM_IRQ_STAT_IDX)) begin
            decodeAddr = SEL_STAT;
         end else if (addr == byteAddr(`PM_IRQ_MASK_IDX)) begin
            decodeAddr = SEL_MASK;
         end else begin
            decodeAddr = SEL_NONE;
         end
      end
   endfunction

   // Fixed capability value assembled field by field
   wire [15:0] capValue;
   localparam [4:0] WAKE_SUP = `CAP_WAKE_SUP_VAL; // [RULE_01]
   assign capValue[`CAP_WAKE_SUP_HI] = WAKE_SUP[4]; // [RULE_02]
   assign capValue[`CAP_WAKE_SUP_HI - 1] = WAKE_SUP[3]; // [RULE_03]
   assign capValue[`CAP_WAKE_SUP_HI - 2] = WAKE_SUP[2]; // [RULE_04]
   assign capValue[`CAP_WAKE_SUP_HI - 3] = WAKE_SUP[1]; // [RULE_05]
   // Lowest wake bit stands for the fully-on state
   assign capValue[`CAP_WAKE_SUP_LO] = WAKE_SUP[0]; // [RULE_06] [RULE_07]
   assign capValue[`CAP_D2_BIT] = `CAP_D2_VAL; // [RULE_08]
   assign capValue[`CAP_D1_BIT] = `CAP_D1_VAL; // [RULE_09]
   assign capValue[`CAP_RSVD_HI:`CAP_RSVD_LO] = `CAP_RSVD_VAL; // [RULE_10]
   assign capValue[`CAP_DSI_BIT] = `CAP_DSI_VAL; // [RULE_11]
   assign capValue[`CAP_AUX_BIT] = `CAP_AUX_VAL; // [RULE_12]
   assign capValue[`CAP_CLK_BIT] = `CAP_CLK_VAL; // [RULE_13]
   assign capValue[`CAP_VER_HI:`CAP_VER_LO] = `CAP_VER_VAL; // [RULE_14]

   // Write channel holding state
   reg [ADDR_W-1:0] awAddr_q;
   reg awHeld_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg wHeld_q;
   wire doWrite;
   wire [2:0] wrSel;
   assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign wrSel = decodeAddr(awAddr_q);

   // Control state
   reg wakeEnable_q;
   reg [1:0] powerState_q;
   reg [1:0] powerState_d;
   reg wakeEnable_d;
   reg [`IRQ_W-1:0] irqStat_q;
   reg [`IRQ_W-1:0] irqStat_d;
   reg [`IRQ_W-1:0] irqMask_q;
   reg [`IRQ_W-1:0] irqMask_d;
   wire wakeFlag;
   wire wakeSync;
   reg wakePrev_q;
   wire wakeEvent;
   reg wakeClear;
   reg pstateChanged;

   sync2 u_wake_sync (
      .mclk(mclk),
      .rstn(rstn),
      .asyncIn(wakeEventPin),
      .syncOut(wakeSync)
   );

   // Rising edge of the synchronised event; counts in every power state
   assign wakeEvent = wakeSync & ~wakePrev_q; // [RULE_07]

   wake_event_ctrl u_wake (
      .mclk(mclk),
      .rstn(rstn),
      .eventPulse(wakeEvent),
      .clearReq(wakeClear),
      .wakeEnable(wakeEnable_d),
      .wakeFlag(wakeFlag),
      .wakeOut(wakeOut)
   ); // [RULE_16] [RULE_17]

   // Register write effects
   always @* begin
      powerState_d = powerState_q;
      wakeEnable_d = wakeEnable_q;
      irqMask_d = irqMask_q;
      wakeClear = 1'b0;
      pstateChanged = 1'b0;
      irqStat_d = irqStat_q;
      if (doWrite) begin
         if (wrSel == SEL_CSR) begin
            if (wStrb_q[0]) begin
               powerState_d =
                  wData_q[`CSR_PSTATE_HI:`CSR_PSTATE_LO]; // [RULE_18]
               pstateChanged = (powerState_d != powerState_q);
            end
            if (wStrb_q[1]) begin
               wakeEnable_d = wData_q[`CSR_WAKE_EN_BIT]; // [RULE_17]
               wakeClear = wData_q[`CSR_WAKE_FLAG_BIT]; // [RULE_16]
            end
         end else if (wrSel == SEL_STAT) begin
            if (wStrb_q[0]) begin
               irqStat_d = irqStat_q & ~wData_q[`IRQ_W-1:0];
            end
         end else if (wrSel == SEL_MASK) begin
            if (wStrb_q[0]) begin
               irqMask_d = wData_q[`IRQ_W-1:0];
            end
         end
      end
      // Events win over a same-cycle clear
      if (wakeEvent) begin
         irqStat_d[`IRQ_WAKE_BIT] = 1'b1;
      end
      if (pstateChanged) begin
         irqStat_d[`IRQ_PSTATE_BIT] = 1'b1;
      end
   end

   // Pending sources after this cycle's events and writes
   wire [`IRQ_W-1:0] irqPend_d;
   assign irqPend_d = irqStat_d & irqMask_d;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         powerState_q <= CSR_INIT[`CSR_PSTATE_HI:`CSR_PSTATE_LO];
         wakeEnable_q <= CSR_INIT[`CSR_WAKE_EN_BIT];
         irqStat_q <= `IRQ_STAT_RESET;
         irqMask_q <= `IRQ_MASK_RESET;
         wakePrev_q <= 1'b0;
         powerStateOut <= CSR_INIT[`CSR_PSTATE_HI:`CSR_PSTATE_LO];
         irq <= 1'b0;
      end else begin
         powerState_q <= powerState_d;
         wakeEnable_q <= wakeEnable_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         wakePrev_q <= wakeSync;
         powerStateOut <= powerState_d;
         irq <= |irqPend_d;
      end
   end

   // Write address, data and response channels
   // Address and data may arrive in either order; each waits for the other
   // Protection attributes are accepted and not decoded
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         awAddr_q <= {ADDR_W{1'b0}};
         awHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         wHeld_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
            awHeld_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHeld_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Capability writes are accepted and have no effect
            if (wrSel == SEL_NONE) begin
               s_axi_bresp <= `RESP_SLVERR;
            end else begin
               s_axi_bresp <= `RESP_OKAY; // [RULE_15]
            end
         end
         // Both channels reopen once the response is taken
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channels
   // Data is captured at the address handshake and held until taken
   reg [31:0] rdWord;
   reg rdErr;
   always @* begin
      rdWord = 32'h0000_0000;
      rdErr = 1'b0;
      case (decodeAddr(s_axi_araddr))
         SEL_CAP: begin
            rdWord[15:0] = capValue; // [RULE_15]
         end
         SEL_CSR: begin
            rdWord[`CSR_WAKE_FLAG_BIT] = wakeFlag; // [RULE_16]
            rdWord[`CSR_WAKE_EN_BIT] = wakeEnable_q;
            rdWord[`CSR_PSTATE_HI:`CSR_PSTATE_LO] = powerState_q; // [RULE_18]
         end
         SEL_STAT: begin
            rdWord[`IRQ_W-1:0] = irqStat_q;
         end
         SEL_MASK: begin
            rdWord[`IRQ_W-1:0] = irqMask_q;
         end
         default: begin
            rdErr = 1'b1;
         end
      endcase
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

//--- test/pm_regs_chk.sv
// Assertion checker for the power-management register block
`timescale 1ns/1ps
`include "pm_regs_defines.vh"
module pm_regs_chk #(
   parameter ADDR_W = 12
) (
   input wire mclk,
   input wire rstn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire wakeOut,
   input wire [1:0] powerStateOut
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire capRd = s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == {`PM_CAP_IDX, 2'b00};
   wire wrOk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire capWr = wrOk && s_axi_awaddr == {`PM_CAP_IDX, 2'b00};
   wire csrWr = wrOk && s_axi_awaddr == {`PM_CSR_IDX, 2'b00};
   property p_cap_wake; capRd |=> s_axi_rvalid && s_axi_rdata[15:11] == 5'h0F;
   endproperty
   a_cap_wake: assert property (p_cap_wake)
      else $error("capability wake field wrong");
   property p_cap_dst; capRd |=> s_axi_rdata[10:9] == 2'b11; endproperty
   a_cap_dst: assert property (p_cap_dst)
      else $error("capability state support wrong");
   property p_cap_rsvd; capRd |=> s_axi_rdata[8:6] == 3'h0; endproperty
   a_cap_rsvd: assert property (p_cap_rsvd)
      else $error("capability reserved bits wrong");
   property p_cap_flags; capRd |=> s_axi_rdata[5:3] == 3'h4; endproperty
   a_cap_flags: assert property (p_cap_flags)
      else $error("capability flag bits wrong");
   property p_cap_ver; capRd |=> s_axi_rdata[2:0] == 3'h1; endproperty
   a_cap_ver: assert property (p_cap_ver)
      else $error("capability version wrong");
   property p_cap_wr;
      capWr |-> ##[1:4] s_axi_bvalid && s_axi_bresp == `RESP_OKAY;
   endproperty
   a_cap_wr: assert property (p_cap_wr)
      else $error("capability write not answered okay");
   property p_pstate;
      csrWr && s_axi_wstrb[0] |=>
         ##1 powerStateOut == $past(s_axi_wdata[1:0], 2);
   endproperty
   a_pstate: assert property (p_pstate)
      else $error("power state not taken from write");
   property p_wake_gate;
      csrWr && s_axi_wstrb[1] && !s_axi_wdata[8] |=> ##1 !wakeOut [*3];
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("wake driven while disabled");
endmodule

//--- test/pm_regs_top_test.sv
// Self-checking bench for the power-management register block
`timescale 1ns/1ps
`include "pm_regs_defines.vh"
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module pm_regs_top_test;
   localparam [11:0] CAP = {`PM_CAP_IDX, 2'b00};
   localparam [11:0] CSR = {`PM_CSR_IDX, 2'b00};
   localparam [11:0] STA = {`PM_IRQ_STAT_IDX, 2'b00};
   localparam [11:0] MSK = {`PM_IRQ_MASK_IDX, 2'b00};
   reg mclk = 0, rstn = 0, awValid = 0, wValid = 0, bReady = 0;
   reg arValid = 0, rReady = 0, wakePin = 0;
   reg [11:0] awAddr = 0, arAddr = 0;
   reg [31:0] wData = 0, rdD;
   reg [3:0] wStrb = 0;
   reg [1:0] rdR;
   wire awReady, wReady, bValid, arReady, rValid, wakeOut, irq;
   wire [1:0] bResp, rResp, pState;
   wire [31:0] rData;
   integer mismatches = 0, nChecks = 0, cycles = 0, i;
   pm_regs_top pm_regs_top_inst (.mclk(mclk), .rstn(rstn),
      .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .wakeEventPin(wakePin), .wakeOut(wakeOut),
      .powerStateOut(pState), .irq(irq));
   initial begin
      forever #25 mclk = ~mclk;
   end
   task print_verdict;
      begin
         if (mismatches == 0 && nChecks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end
   task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      reg aw, w;
      begin
         @(posedge mclk);
         awAddr <= a;
         wData <= d;
         wStrb <= s;
         awValid <= 1'b1;
         wValid <= 1'b1;
         bReady <= 1'b1;
         aw = 1'b1;
         w = 1'b1;
         while (aw || w) begin
            @(posedge mclk);
            if (awReady === 1'b1)
               aw = 1'b0;
            if (wReady === 1'b1)
               w = 1'b0;
            awValid <= aw;
            wValid <= w;
         end
         do @(posedge mclk); while (bValid !== 1'b1);
         bReady <= 1'b0;
         `CHK("bresp", er, bResp)
      end
   endtask
   task rd(input [11:0] a);
      begin
         @(posedge mclk);
         arAddr <= a;
         arValid <= 1'b1;
         rReady <= 1'b1;
         do @(posedge mclk); while (arReady !== 1'b1);
         arValid <= 1'b0;
         do @(posedge mclk); while (rValid !== 1'b1);
         rReady <= 1'b0;
         rdD = rData;
         rdR = rResp;
      end
   endtask
   task settle;
      repeat (2) @(negedge mclk);
   endtask
   task pulse;
      begin
         @(posedge mclk);
         wakePin <= 1'b1;
         repeat (3) @(posedge mclk);
         wakePin <= 1'b0;
         repeat (6) @(posedge mclk);
      end
   endtask
   task t_cap;
      begin
         rd(CAP);
         `CHK("cap", 32'h0000_7E21, rdD)
         `CHK("cap d3cold", 1'b0, rdD[15])
         `CHK("cap d3hot", 1'b1, rdD[14])
         `CHK("cap d2 wake", 1'b1, rdD[13])
         `CHK("cap d1 wake", 1'b1, rdD[12])
         `CHK("cap d0 wake", 1'b1, rdD[11])
         `CHK("cap states", 2'h3, rdD[10:9])
         `CHK("cap reserved", 3'h0, rdD[8:6])
         `CHK("cap dsi", 1'b1, rdD[5])
         `CHK("cap aux", 1'b0, rdD[4])
         `CHK("cap clock", 1'b0, rdD[3])
         `CHK("cap resp", `RESP_OKAY, rdR)
         wr(CAP, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
         wr(CAP, 32'h0000_0000, 4'hF, `RESP_OKAY);
         rd(CAP);
         `CHK("cap after write", 32'h0000_7E21, rdD)
      end
   endtask
   task t_pstate;
      begin
         settle;
         `CHK("reset state", 2'h0, pState)
         for (i = 0; i < 4; i = i + 1) begin
            wr(CSR, i, 4'h1, `RESP_OKAY);
            settle;
            `CHK("state out", i[1:0], pState)
            rd(CSR);
            `CHK("csr", i, rdD)
         end
         rd(STA);
         `CHK("status", 32'h0000_0002, rdD)
         wr(MSK, 32'h0000_0002, 4'h1, `RESP_OKAY);
         settle;
         `CHK("irq on", 1'b1, irq)
         wr(MSK, 32'h0000_0000, 4'h1, `RESP_OKAY);
         settle;
         `CHK("irq masked", 1'b0, irq)
         wr(MSK, 32'h0000_0002, 4'h1, `RESP_OKAY);
         wr(STA, 32'h0000_0002, 4'h1, `RESP_OKAY);
         settle;
         `CHK("irq cleared", 1'b0, irq)
      end
   endtask
   task t_wake;
      begin
         pulse;
         settle;
         `CHK("wake off", 1'b0, wakeOut)
         rd(CSR);
         `CHK("flag set", 32'h0000_8003, rdD)
         wr(CSR, 32'h0000_0100, 4'h2, `RESP_OKAY);
         settle;
         `CHK("wake on", 1'b1, wakeOut)
         wr(CSR, 32'h0000_8100, 4'h2, `RESP_OKAY);
         settle;
         `CHK("wake cleared", 1'b0, wakeOut)
         rd(CSR);
         `CHK("flag clear", 32'h0000_0103, rdD)
         pulse;
         wr(CSR, 32'h0000_0000, 4'h2, `RESP_OKAY);
         settle;
         `CHK("wake gated", 1'b0, wakeOut)
         rd(CSR);
         `CHK("flag kept", 32'h0000_8003, rdD)
         wr(CSR, 32'h0000_8000, 4'h3, `RESP_OKAY);
         rd(CSR);
         `CHK("flag cleared d0", 32'h0000_0000, rdD)
         pulse;
         rd(CSR);
         `CHK("flag in d0", 32'h0000_8000, rdD)
      end
   endtask
   task t_unmapped;
      begin
         wr(12'h100, 32'h0000_FFFF, 4'hF, `RESP_SLVERR);
         rd(12'h100);
         `CHK("unmapped resp", `RESP_SLVERR, rdR)
         `CHK("unmapped data", 32'h0000_0000, rdD)
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_pstate;
      t_cap;
      t_wake;
      t_unmapped;
      print_verdict;
   end
endmodule
bind pm_regs_top pm_regs_chk #(.ADDR_W(ADDR_W)) pm_regs_chk_inst (
   .mclk(mclk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .wakeOut(wakeOut),
   .powerStateOut(powerStateOut));
